// *** include/fpcr_consts.vh ***
`ifndef FPCR_CONSTS_VH
`define FPCR_CONSTS_VH

// Register word indices (byte address = index * 4)
`define FPCR_IDX_OUTCTL     6'h17
`define FPCR_IDX_MODECTL    6'h18
`define FPCR_IDX_DEV_FIRST  6'h19
`define FPCR_IDX_DEV_LAST   6'h20
`define FPCR_IDX_FSKCTL     6'h22
`define FPCR_IDX_STATUS     6'h23

// Reset values
`define FPCR_RST_OUTCTL     16'h10a4
`define FPCR_RST_MODECTL    16'h0010
`define FPCR_RST_DEV        16'h0000
`define FPCR_RST_FSKCTL     16'h0000

// Mode control fields
`define FPCR_MC_FSK_EN      10
`define FPCR_MC_DIV_HI      9
`define FPCR_MC_DIV_LO      6
`define FPCR_MC_EXT_SEL     5
`define FPCR_MC_TXP_HI      4
`define FPCR_MC_TXP_LO      0

// Output control fields
`define FPCR_OC_RXP_HI      12
`define FPCR_OC_RXP_LO      8
`define FPCR_OC_TX_EN       7
`define FPCR_OC_RX_EN       6

// FSK control fields
`define FPCR_FC_LVL_HI      6
`define FPCR_FC_LVL_LO      5
`define FPCR_FC_SEL_HI      4
`define FPCR_FC_SEL_LO      2
`define FPCR_FC_MODE0       1
`define FPCR_FC_MODE1       0

// Divider codes
`define FPCR_DIV_ONE        4'h0
`define FPCR_DIV_MIN        4'h2
`define FPCR_DIV_RSV        4'h1
`define FPCR_DIV_MAX        4'ha

// FSK modes
`define FPCR_MODE_PIN       2'h0
`define FPCR_MODE_SERIAL    2'h1
`define FPCR_MODE_AUDIO     2'h2
`define FPCR_MODE_FAST      2'h3
`define FPCR_LVL_OFF        2'h0

`endif

// *** design/fpcr_dev_select.v ***
`timescale 1ns/1ps
// ****************************************
// Deviation word picker
// ****************************************
module fpcr_dev_select #(
    parameter W = 16
) (
    input  wire [8*W-1:0] words_i,
    input  wire [1:0]     mode_i,
    input  wire [1:0]     level_i,
    input  wire [2:0]     sel_i,
    input  wire [2:0]     pins_i,
    output wire [2:0]     index_o,
    output wire [W-1:0]   word_o
);
    reg [2:0] idx;
    always @* begin
        case (mode_i)
            // Level-limited pin symbol
            2'h0: begin
                case (level_i)
                    2'h1:    idx = {2'h0, pins_i[0]};
                    2'h2:    idx = {1'b0, pins_i[1:0]};
                    default: idx = pins_i;
                endcase
            end
            default: idx = sel_i;
        endcase
    end
    assign index_o = idx;
    assign word_o  = words_i[idx*W +: W];
endmodule // fpcr_dev_select

// *** design/fpcr_regs.v ***
// Our own choice: register access over Wishbone.
`timescale 1ns/1ps
`include "fpcr_consts.vh"

// Overview of operation
// - Eight 16-bit deviation words reset to zero and feed pin and serial FSK.
// - Deviation words 0 to 7 sit at consecutive indices 19h to 20h.
// - Mode control bit 10 turns FSK on alone in audio and fast modes; pin and serial FSK also need a nonzero count_a.
// - Bits 9-6 set the external oscillator divider, codes 1 and 11-15 reserved.
// - Mode control bit 5 selects internal synthesizer or external PLL operation.
// - Mode control bits 4-0 set transmit power, reset 10h.
// - Output control bits 12-8 set receive power, reset 10h.
// - Output control bit 7 enables the transmit output, reset 1.
// - Output control bit 6 enables the receive output, reset 0.
// - In serial FSK a 3-bit selector picks deviation word 0 to 7.
// - Count_a codes 1-3 give 2, 4, 8 levels and code 0 disables pin and serial FSK.
// - A 2-bit selector picks pin, serial, audio-serial or fast serial FSK mode.
module fpcr_regs #(
    parameter DW = 16
) (
    input  wire          CLK_I,
    input  wire          RSTN_I,
    input  wire          CYC_I,
    input  wire          STB_I,
    input  wire          WE_I,
    input  wire [7:0]    ADR_I,
    input  wire [31:0]   DAT_I,
    input  wire [3:0]    SEL_I,
    output reg  [31:0]   DAT_O,
    output reg           ACK_O,
    input  wire          PROFILE2_ACTIVE_I,
    input  wire [2:0]    FSK_PINS_I,
    output reg           FSK_ACTIVE_O,
    output reg  [1:0]    FSK_MODE_O,
    output reg  [DW-1:0] DEVIATION_O,
    output reg           EXT_OSC_SELECT_O,
    output reg  [3:0]    EXT_OSC_DIVIDE_O,
    output reg           DIVIDER_RESERVED_O,
    output reg  [4:0]    TX_POWER_O,
    output reg  [4:0]    RX_POWER_O,
    output reg           TX_ENABLE_O,
    output reg           RX_ENABLE_O,
    output reg           PROFILE_APPLIED_O
);
    // ****************************************
    // Storage
    // ****************************************
    reg  [15:0]     out_ctl;
    reg  [15:0]     mode_ctl;
    reg  [15:0]     fsk_ctl;
    reg  [DW-1:0]   dev [0:7];
    reg  [2:0]      pin_s1;
    reg  [2:0]      pin_s2;
    reg             act_s1;
    reg             act_s2;
    wire [5:0]      idx = ADR_I[7:2];
    wire            req = CYC_I & STB_I & ~ACK_O;
    wire            is_dev = (idx >= `FPCR_IDX_DEV_FIRST) && (idx <= `FPCR_IDX_DEV_LAST);
    wire [2:0]      dev_n = idx[2:0] - 3'h1;
    wire [8*DW-1:0] dev_flat;
    wire [2:0]      pick_idx;
    wire [DW-1:0]   pick_word;
    integer         k;

    // Byte-lane merge of a 16-bit register
    function [15:0] merge;
        input [15:0] old;
        input [31:0] wd;
        input [3:0]  sel;
        begin
            merge = {sel[1] ? wd[15:8] : old[15:8], sel[0] ? wd[7:0] : old[7:0]};
        end
    endfunction

    // ****************************************
    // Bus slave
    // ****************************************
    always @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            out_ctl  <= `FPCR_RST_OUTCTL;
            mode_ctl <= `FPCR_RST_MODECTL;
            fsk_ctl  <= `FPCR_RST_FSKCTL;
            ACK_O    <= 1'b0;
            DAT_O    <= 32'h0000_0000;
            for (k = 0; k < 8; k = k + 1) begin
                dev[k] <= `FPCR_RST_DEV;
            end
        end else begin
            ACK_O <= req;
            DAT_O <= 32'h0000_0000;
            if (req && WE_I) begin
                if (idx == `FPCR_IDX_OUTCTL) begin
                    out_ctl <= merge(out_ctl, DAT_I, SEL_I);
                end
                if (idx == `FPCR_IDX_MODECTL) begin
                    mode_ctl <= merge(mode_ctl, DAT_I, SEL_I);
                end
                if (idx == `FPCR_IDX_FSKCTL) begin
                    fsk_ctl <= merge(fsk_ctl, DAT_I, SEL_I);
                end
                if (is_dev) begin
                    dev[dev_n] <= merge(dev[dev_n], DAT_I, SEL_I);
                end
            end else if (req) begin
                if (idx == `FPCR_IDX_OUTCTL) begin
                    DAT_O <= {16'h0000, out_ctl};
                end else if (idx == `FPCR_IDX_MODECTL) begin
                    DAT_O <= {16'h0000, mode_ctl};
                end else if (idx == `FPCR_IDX_FSKCTL) begin
                    DAT_O <= {16'h0000, fsk_ctl};
                end else if (idx == `FPCR_IDX_STATUS) begin
                    DAT_O <= {24'h0, 1'b0, pick_idx, PROFILE_APPLIED_O, FSK_ACTIVE_O,
                              DIVIDER_RESERVED_O, act_s2};
                end else if (is_dev) begin
                    DAT_O <= {16'h0000, dev[dev_n]};
                end
            end
        end
    end

    // ****************************************
    // Pin synchronisers
    // ****************************************
    always @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            pin_s1 <= 3'h0;
            pin_s2 <= 3'h0;
            act_s1 <= 1'b0;
            act_s2 <= 1'b0;
        end else begin
            pin_s1 <= FSK_PINS_I;
            pin_s2 <= pin_s1;
            act_s1 <= PROFILE2_ACTIVE_I;
            act_s2 <= act_s1;
        end
    end

    // ****************************************
    // Deviation selection
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_flat
            assign dev_flat[g*DW +: DW] = dev[g];
        end
    endgenerate

    fpcr_dev_select #(
        .W (DW)
    ) u_pick (
        .words_i (dev_flat),
        .mode_i  ({fsk_ctl[`FPCR_FC_MODE1], fsk_ctl[`FPCR_FC_MODE0]}),
        .level_i (fsk_ctl[`FPCR_FC_LVL_HI:`FPCR_FC_LVL_LO]),
        .sel_i   (fsk_ctl[`FPCR_FC_SEL_HI:`FPCR_FC_SEL_LO]),
        .pins_i  (pin_s2),
        .index_o (pick_idx),
        .word_o  (pick_word)
    );

    // ****************************************
    // Applied settings
    // ****************************************
    wire [1:0] mode  = {fsk_ctl[`FPCR_FC_MODE1], fsk_ctl[`FPCR_FC_MODE0]};
    wire [1:0] level = fsk_ctl[`FPCR_FC_LVL_HI:`FPCR_FC_LVL_LO];
    wire [3:0] dcode = mode_ctl[`FPCR_MC_DIV_HI:`FPCR_MC_DIV_LO];
    wire table_mode = (mode == `FPCR_MODE_PIN) || (mode == `FPCR_MODE_SERIAL);
    wire lvl_ok = !table_mode || (level != `FPCR_LVL_OFF);
    wire fsk_on = mode_ctl[`FPCR_MC_FSK_EN] && lvl_ok;
    wire div_bad = (dcode == `FPCR_DIV_RSV) || (dcode > `FPCR_DIV_MAX);

    always @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            FSK_ACTIVE_O       <= 1'b0;
            FSK_MODE_O         <= `FPCR_MODE_PIN;
            DEVIATION_O        <= {DW{1'b0}};
            EXT_OSC_SELECT_O   <= 1'b0;
            EXT_OSC_DIVIDE_O   <= 4'h1;
            DIVIDER_RESERVED_O <= 1'b0;
            TX_POWER_O         <= 5'h00;
            RX_POWER_O         <= 5'h00;
            TX_ENABLE_O        <= 1'b0;
            RX_ENABLE_O        <= 1'b0;
            PROFILE_APPLIED_O  <= 1'b0;
        end else begin
            PROFILE_APPLIED_O <= act_s2;
            if (act_s2) begin
                FSK_ACTIVE_O       <= fsk_on;
                FSK_MODE_O         <= mode;
                DEVIATION_O        <= (fsk_on && table_mode) ? pick_word : {DW{1'b0}};
                EXT_OSC_SELECT_O   <= mode_ctl[`FPCR_MC_EXT_SEL];
                EXT_OSC_DIVIDE_O   <= (dcode == `FPCR_DIV_ONE || div_bad) ? `FPCR_DIV_RSV : dcode;
                DIVIDER_RESERVED_O <= div_bad;
                TX_POWER_O         <= mode_ctl[`FPCR_MC_TXP_HI:`FPCR_MC_TXP_LO];
                RX_POWER_O         <= out_ctl[`FPCR_OC_RXP_HI:`FPCR_OC_RXP_LO];
                TX_ENABLE_O        <= out_ctl[`FPCR_OC_TX_EN];
                RX_ENABLE_O        <= out_ctl[`FPCR_OC_RX_EN];
            end
        end
    end
endmodule // fpcr_regs

// *** test/fpcr_regs_properties.sv ***
`timescale 1ns/1ps
module fpcr_regs_properties #(
    parameter DW = 16
) (
    input wire logic          CLK_I,
    input wire logic          RSTN_I,
    input wire logic          CYC_I,
    input wire logic          STB_I,
    input wire logic          WE_I,
    input wire logic [7:0]    ADR_I,
    input wire logic [31:0]   DAT_I,
    input wire logic [3:0]    SEL_I,
    input wire logic [31:0]   DAT_O,
    input wire logic          ACK_O,
    input wire logic          PROFILE2_ACTIVE_I,
    input wire logic          FSK_ACTIVE_O,
    input wire logic [1:0]    FSK_MODE_O,
    input wire logic [DW-1:0] DEVIATION_O,
    input wire logic          EXT_OSC_SELECT_O,
    input wire logic [3:0]    EXT_OSC_DIVIDE_O,
    input wire logic          DIVIDER_RESERVED_O,
    input wire logic [4:0]    TX_POWER_O,
    input wire logic [4:0]    RX_POWER_O,
    input wire logic          TX_ENABLE_O,
    input wire logic          RX_ENABLE_O,
    input wire logic          PROFILE_APPLIED_O
);
    // *****
    // Helpers and properties
    // *****
    logic        tk;
    assign tk = CYC_I && STB_I && !ACK_O;
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RSTN_I);

    property p_ack_next; tk |=> ACK_O; endproperty
    a_ack_next: assert property (p_ack_next) else $error("no ack after request");
    property p_ack_once; ACK_O |=> !ACK_O; endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
    property p_dat_idle; !ACK_O |-> DAT_O == 32'h0; endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
    property p_out_wr;
        PROFILE_APPLIED_O && tk && WE_I && ADR_I == 8'h5c && SEL_I[1:0] == 2'h3
        |=> ##1 {RX_POWER_O, TX_ENABLE_O, RX_ENABLE_O} == $past(DAT_I[12:6], 2);
    endproperty
    a_out_wr: assert property (p_out_wr) else $error("output word not applied");
    property p_mode_wr;
        PROFILE_APPLIED_O && tk && WE_I && ADR_I == 8'h60 && SEL_I[0]
        |=> ##1 {EXT_OSC_SELECT_O, TX_POWER_O} == $past(DAT_I[5:0], 2);
    endproperty
    a_mode_wr: assert property (p_mode_wr) else $error("mode word not applied");
    property p_div_rsv; DIVIDER_RESERVED_O |-> EXT_OSC_DIVIDE_O == 4'h1; endproperty
    a_div_rsv: assert property (p_div_rsv) else $error("reserved divide not one");
    property p_div_rng; EXT_OSC_DIVIDE_O inside {[4'h1:4'ha]}; endproperty
    a_div_rng: assert property (p_div_rng) else $error("divide out of range");
    property p_dev_off; !FSK_ACTIVE_O || FSK_MODE_O[1] |-> DEVIATION_O == '0; endproperty
    a_dev_off: assert property (p_dev_off) else $error("deviation while idle");
    property p_hold;
        !PROFILE2_ACTIVE_I [*4] |->
            $stable({RX_POWER_O, TX_POWER_O, TX_ENABLE_O, RX_ENABLE_O, EXT_OSC_SELECT_O});
    endproperty
    a_hold: assert property (p_hold) else $error("outputs moved while inactive");
    property p_sync; PROFILE2_ACTIVE_I [*4] |-> PROFILE_APPLIED_O; endproperty
    a_sync: assert property (p_sync) else $error("profile not applied in time");
    c_wr: cover property (tk && WE_I ##1 ACK_O);
    c_rd: cover property (tk && !WE_I ##1 ACK_O);
    c_fsk: cover property (FSK_ACTIVE_O && !FSK_MODE_O[1] && DEVIATION_O != '0);
    c_rsv: cover property (DIVIDER_RESERVED_O);
endmodule // fpcr_regs_properties

bind fpcr_regs fpcr_regs_properties #(.DW(DW)) u_props (
    .CLK_I(CLK_I), .RSTN_I(RSTN_I), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
    .ADR_I(ADR_I), .DAT_I(DAT_I), .SEL_I(SEL_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
    .PROFILE2_ACTIVE_I(PROFILE2_ACTIVE_I), .FSK_ACTIVE_O(FSK_ACTIVE_O),
    .FSK_MODE_O(FSK_MODE_O), .DEVIATION_O(DEVIATION_O),
    .EXT_OSC_SELECT_O(EXT_OSC_SELECT_O), .EXT_OSC_DIVIDE_O(EXT_OSC_DIVIDE_O),
    .DIVIDER_RESERVED_O(DIVIDER_RESERVED_O), .TX_POWER_O(TX_POWER_O),
    .RX_POWER_O(RX_POWER_O), .TX_ENABLE_O(TX_ENABLE_O), .RX_ENABLE_O(RX_ENABLE_O),
    .PROFILE_APPLIED_O(PROFILE_APPLIED_O)
);

// *** test/tb.sv ***
`timescale 1ns/1ps
module tb;
    // *****
    // Signals and design
    // *****
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic        act = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [3:0]  sel = 4'hf;
    logic [2:0]  pins = 3'h0;
    logic [15:0] q;
    logic [3:0]  e;
    logic [15:0] words [8];
    wire  [31:0] rdat;
    wire         ack, fsk_act, ext_sel, div_rsv, tx_en, rx_en, applied;
    wire  [1:0]  mode;
    wire  [15:0] dev;
    wire  [3:0]  div;
    wire  [4:0]  tx_pwr, rx_pwr;
    wire  [15:0] outs = {4'h0, tx_en, rx_en, rx_pwr, tx_pwr};
    int          n_errors = 0;
    int          check_count = 0;

    always #4 clk = ~clk;

    fpcr_regs #(.DW(16)) dut (
        .CLK_I(clk), .RSTN_I(rst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
        .DAT_I(wdat), .SEL_I(sel), .DAT_O(rdat), .ACK_O(ack), .PROFILE2_ACTIVE_I(act),
        .FSK_PINS_I(pins), .FSK_ACTIVE_O(fsk_act), .FSK_MODE_O(mode), .DEVIATION_O(dev),
        .EXT_OSC_SELECT_O(ext_sel), .EXT_OSC_DIVIDE_O(div), .DIVIDER_RESERVED_O(div_rsv),
        .TX_POWER_O(tx_pwr), .RX_POWER_O(rx_pwr), .TX_ENABLE_O(tx_en),
        .RX_ENABLE_O(rx_en), .PROFILE_APPLIED_O(applied)
    );

    // *****
    // Tasks
    // *****
    task automatic check(input string nm, input logic [15:0] ex, input logic [15:0] g);
        check_count++;
        if (g !== ex) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, ex, g);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {16'h0, d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat[15:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 50) check("ack", 16'h1, 16'h0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] ex, input string nm);
        wb(1'b0, a, 16'h0);
        check(nm, ex, q);
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        wb(1'b1, a, d);
        repeat (2) @(posedge clk);
    endtask

    task automatic results;
        $display("Checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // *****
    // Tests
    // *****
    initial begin
        #100000;
        n_errors++;
        results;
    end

    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rd(8'h5c, 16'h10a4, "outctl");
        rd(8'h60, 16'h0010, "modectl");
        for (int i = 0; i < 8; i++) begin
            words[i] = {4'(i), 4'(7 - i), 8'h3c};
            rd(8'h64 + 8'(4 * i), 16'h0, "dev_rst");
            wb(1'b1, 8'h64 + 8'(4 * i), words[i]);
        end
        for (int i = 0; i < 8; i++) rd(8'h64 + 8'(4 * i), words[i], "dev");
        wb(1'b1, 8'h84, 16'hffff);
        rd(8'h84, 16'h0, "unmapped");
        act <= 1'b1;
        repeat (5) @(posedge clk);
        check("outs", {4'h0, 2'b10, 5'h10, 5'h10}, outs);
        wr(8'h5c, 16'h1f40);
        check("outs", {4'h0, 2'b01, 5'h1f, 5'h10}, outs);
        wr(8'h5c, 16'h0080);
        check("outs", {4'h0, 2'b10, 5'h00, 5'h10}, outs);
        for (int c = 0; c < 16; c++) begin
            wr(8'h60, {6'h0, 4'(c), 1'b1, 5'h15});
            e = (c < 2 || c > 10) ? 4'h1 : 4'(c);
            check("div", {12'h0, e}, {12'h0, div});
            check("div_rsv", {15'h0, c == 1 || c > 10}, {15'h0, div_rsv});
            check("sel_pwr", 16'h0035, {10'h0, ext_sel, tx_pwr});
        end
        wr(8'h60, 16'h0400);
        check("sel_pwr", 16'h0, {10'h0, ext_sel, tx_pwr});
        for (int s = 0; s < 8; s++) begin
            wr(8'h88, {9'h0, 2'h3, 3'(s), 2'b10});
            check("dev_ser", words[s], dev);
        end
        wr(8'h88, {9'h0, 2'h0, 3'h2, 2'b10});
        check("lvl_off", 16'h0, {15'h0, fsk_act});
        for (int m = 0; m < 4; m++) begin
            wr(8'h88, {9'h0, 2'h1, 3'h0, 1'(m), 1'(m >> 1)});
            check("mode", 16'(m), {14'h0, mode});
            check("fsk_on", 16'h1, {15'h0, fsk_act});
        end
        wr(8'h60, 16'h0000);
        check("fsk_en_off", 16'h0, {15'h0, fsk_act});
        wr(8'h60, 16'h0400);
        pins <= 3'h5;
        wr(8'h88, {9'h0, 2'h3, 3'h0, 2'b00});
        repeat (4) @(posedge clk);
        check("dev_pin8", words[5], dev);
        wr(8'h88, {9'h0, 2'h1, 3'h0, 2'b00});
        check("dev_pin2", words[1], dev);
        act <= 1'b0;
        repeat (5) @(posedge clk);
        wr(8'h5c, 16'h1fc0);
        check("hold", {4'h0, 2'b10, 5'h00, 5'h00}, outs);
        act <= 1'b1;
        repeat (5) @(posedge clk);
        check("apply", {4'h0, 2'b11, 5'h1f, 5'h00}, outs);
        rd(8'h8c, 16'h001d, "status");
        results;
    end
endmodule // tb
